// file: include/sbsc_pkg.sv
// Constants and carrier types for the serial bus signal control block
package sbsc_pkg;
    // Register map (byte addresses)
    localparam logic [15:0] SBSC_ADDR_MODE = 16'hff60;
    localparam logic [15:0] SBSC_ADDR_CTRL = 16'hff61;
    localparam logic [15:0] SBSC_ADDR_ITIM = 16'hff62;
    // Mode register fields
    localparam int SBSC_MODE_ENABLE = 7;
    localparam int SBSC_MODE_MATCH = 6;
    localparam int SBSC_MODE_WAKEUP = 5;
    localparam logic [7:0] SBSC_MODE_RESET = 8'h00;
    localparam logic [7:0] SBSC_MODE_WMASK = 8'hbf;
    // Control register fields
    localparam int SBSC_CTRL_BUSY_EN = 7;
    localparam int SBSC_CTRL_ACK_DET = 6;
    localparam int SBSC_CTRL_AUTO_ACK = 5;
    localparam int SBSC_CTRL_ACK_TRIG = 4;
    localparam int SBSC_CTRL_CMD_DET = 3;
    localparam int SBSC_CTRL_REL_DET = 2;
    localparam int SBSC_CTRL_CMD_TRIG = 1;
    localparam int SBSC_CTRL_REL_TRIG = 0;
    localparam logic [7:0] SBSC_CTRL_RESET = 8'h00;
    // Interrupt timing register fields
    localparam int SBSC_ITIM_CLK_LEVEL = 6;
    localparam logic [7:0] SBSC_ITIM_RESET = 8'h00;
    localparam logic [7:0] SBSC_ITIM_WMASK = 8'hb0;
    // Data bits per frame before the acknowledge clock
    localparam logic [3:0] SBSC_FRAME_BITS = 4'h8;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sbsc_req_t;

    typedef struct packed {
        logic start;
        logic mismatch;
        logic load;
        logic bit_out;
    } sbsc_shift_t;
endpackage

// file: hdl/sbsc_top.sv
// Control and status flag logic for the multi-drop serial bus mode
//
// Local design decision: the strobed register port.
`timescale 1ns/100ps
// How it works
// RULE1: Control register clears to all zeros on reset.
// RULE2: Writing release trigger sets output latch high; trigger then self-clears.
// RULE3: Writing command trigger clears output latch low; trigger then self-clears.
// RULE4: Both line triggers forced to zero while channel disabled.
// RULE5: Release flag set when a release condition appears on the bus.
// RULE6: Release flag cleared by start, wakeup address mismatch, disable or reset.
// RULE7: Command flag set when a command condition appears on the bus.
// RULE8: Command flag cleared by start, release condition, disable or reset.
// RULE9: Manual ack trigger drives ack at next clock fall, then self-clears.
// RULE10: Manual trigger cleared at start or disable; used only after completion.
// RULE11: With auto ack off, ack only comes from the manual trigger.
// RULE12: Auto ack enabled before completion drives ack at the ninth clock fall.
// RULE13: Auto ack enabled after completion acks at next fall; enable stays set.
// RULE14: Ack flag set when ack sampled on a clock rise after completion.
// RULE15: Ack flag cleared at the fall after busy release following start.
// RULE16: With busy enable set, busy driven at the fall following ack.
// RULE17: Clearing busy enable ends busy at the next clock fall; ready follows.
// RULE18: Transfer start releases busy mode but leaves busy enable unchanged.
// RULE19: The three detection flags are read-only.
// RULE20: The three trigger bits read back as zero.
// RULE21: Interrupt timing register resets to zero; software writes bits 3..0 zero.
// RULE22: Clock level status is read-only and reads zero while disabled.
// RULE23: Release condition is data line rising while clock line is high.
// RULE24: Command condition is data line falling while clock line is high.
// RULE25: Channel enable is mode register bit 7; one enables operation.
// RULE26: Bus lines are synchronised and edge-detected on the internal clock.
module sbsc_top (
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic CE,
    input wire sbsc_pkg::sbsc_req_t REQ,
    output logic [7:0] RDATA,
    input wire sbsc_pkg::sbsc_shift_t SHIFT,
    input wire logic SCK_IN,
    input wire logic SDA_IN,
    output logic SDA_O,
    output logic SDA_OE_N,
    output logic CHAN_EN,
    output logic WAKEUP_EN,
    output logic XFER_DONE
);
    import sbsc_pkg::*;

    typedef enum logic [1:0] {
        SBSC_ST_READY,
        SBSC_ST_ACK,
        SBSC_ST_BUSY
    } sbsc_state_t;

    logic [7:0] mode_reg;
    logic [7:0] itim_reg;
    logic busy_enable;
    logic auto_ack_enable;
    logic manual_ack_trigger;
    logic release_trigger;
    logic command_trigger;
    logic release_detected;
    logic command_detected;
    logic ack_detected;
    logic serial_output_latch;
    logic channel_op_enable;
    logic wakeup_enable;
    logic sck_s1, sck_s2, sck_s3;
    logic sda_s1, sda_s2, sda_s3;
    logic sck_rise, sck_fall, sda_rise, sda_fall;
    logic rel_cond, cmd_cond;
    logic wr_mode, wr_ctrl, wr_itim;
    logic [3:0] bit_count;
    logic frame_done;
    logic ack_given;
    logic start_pending;
    logic ack_request;
    sbsc_state_t state;
    sbsc_state_t next_state;
    logic next_drive_low;
    logic [7:0] next_rdata;

    assign channel_op_enable = mode_reg[SBSC_MODE_ENABLE]; // [RULE25]
    assign wakeup_enable = mode_reg[SBSC_MODE_WAKEUP];
    assign wr_mode = REQ.wr && (REQ.addr == SBSC_ADDR_MODE);
    assign wr_ctrl = REQ.wr && (REQ.addr == SBSC_ADDR_CTRL);
    assign wr_itim = REQ.wr && (REQ.addr == SBSC_ADDR_ITIM);

    // Pin synchronisers; only the second and third stages feed logic
    always_ff @(posedge MCLK) begin // [RULE26]
        if (SRST) begin
            sck_s1 <= 1'b1;
            sck_s2 <= 1'b1;
            sck_s3 <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_s3 <= 1'b1;
        end else if (CE) begin
            sck_s1 <= SCK_IN;
            sck_s2 <= sck_s1;
            sck_s3 <= sck_s2;
            sda_s1 <= SDA_IN;
            sda_s2 <= sda_s1;
            sda_s3 <= sda_s2;
        end
    end

    assign sck_rise = CE && channel_op_enable && sck_s2 && !sck_s3;
    assign sck_fall = CE && channel_op_enable && !sck_s2 && sck_s3;
    assign sda_rise = sda_s2 && !sda_s3;
    assign sda_fall = !sda_s2 && sda_s3;
    // Clock must be high both before and after the data edge
    assign rel_cond = CE && channel_op_enable && sda_rise && sck_s2 && sck_s3; // [RULE23]
    assign cmd_cond = CE && channel_op_enable && sda_fall && sck_s2 && sck_s3; // [RULE24]

    // Mode register
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            mode_reg <= SBSC_MODE_RESET;
        end else if (CE) begin
            if (wr_mode) begin
                mode_reg <= REQ.wdata & SBSC_MODE_WMASK;
            end
        end
    end

    // Interrupt timing register; low nibble is never stored
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            itim_reg <= SBSC_ITIM_RESET; // [RULE21]
        end else if (CE) begin
            if (wr_itim) begin
                itim_reg <= REQ.wdata & SBSC_ITIM_WMASK; // [RULE21]
            end
        end
    end

    // Writable control bits
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            busy_enable <= SBSC_CTRL_RESET[SBSC_CTRL_BUSY_EN]; // [RULE1]
            auto_ack_enable <= SBSC_CTRL_RESET[SBSC_CTRL_AUTO_ACK];
        end else if (CE) begin
            if (wr_ctrl) begin
                busy_enable <= REQ.wdata[SBSC_CTRL_BUSY_EN];
                auto_ack_enable <= REQ.wdata[SBSC_CTRL_AUTO_ACK]; // [RULE13]
            end
        end
    end

    // Line triggers live one cycle: they act on the latch, then drop
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            release_trigger <= SBSC_CTRL_RESET[SBSC_CTRL_REL_TRIG];
            command_trigger <= SBSC_CTRL_RESET[SBSC_CTRL_CMD_TRIG];
        end else if (CE) begin
            if (!channel_op_enable) begin
                release_trigger <= 1'b0; // [RULE4]
                command_trigger <= 1'b0; // [RULE4]
            end else if (wr_ctrl) begin
                release_trigger <= REQ.wdata[SBSC_CTRL_REL_TRIG];
                command_trigger <= REQ.wdata[SBSC_CTRL_CMD_TRIG];
            end else begin
                release_trigger <= 1'b0; // [RULE2]
                command_trigger <= 1'b0; // [RULE3]
            end
        end
    end

    // Output latch; release wins if both triggers are written together
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            serial_output_latch <= 1'b1;
        end else if (CE) begin
            if (release_trigger) begin
                serial_output_latch <= 1'b1; // [RULE2]
            end else if (command_trigger) begin
                serial_output_latch <= 1'b0; // [RULE3]
            end else if (SHIFT.load) begin
                serial_output_latch <= SHIFT.bit_out;
            end
        end
    end

    // Release detection; a new condition outranks any clear
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            release_detected <= 1'b0; // [RULE6]
        end else if (CE) begin
            if (!channel_op_enable) begin
                release_detected <= 1'b0; // [RULE6]
            end else if (rel_cond) begin
                release_detected <= 1'b1; // [RULE5]
            end else if (SHIFT.start || (SHIFT.mismatch && wakeup_enable)) begin
                release_detected <= 1'b0; // [RULE6]
            end
        end
    end

    // Command detection
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            command_detected <= 1'b0; // [RULE8]
        end else if (CE) begin
            if (!channel_op_enable) begin
                command_detected <= 1'b0; // [RULE8]
            end else if (cmd_cond) begin
                command_detected <= 1'b1; // [RULE7]
            end else if (SHIFT.start || rel_cond) begin
                command_detected <= 1'b0; // [RULE8]
            end
        end
    end

    // Frame bit counter: rising clock edges since transfer start
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            bit_count <= 4'h0;
        end else if (CE) begin
            if (!channel_op_enable || SHIFT.start) begin
                bit_count <= 4'h0;
            end else if (sck_rise && !frame_done) begin
                bit_count <= bit_count + 4'h1;
            end
        end
    end

    assign frame_done = (bit_count == SBSC_FRAME_BITS);
    assign XFER_DONE = frame_done;

    // Manual acknowledge trigger
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            manual_ack_trigger <= 1'b0;
        end else if (CE) begin
            if (!channel_op_enable || SHIFT.start) begin
                manual_ack_trigger <= 1'b0; // [RULE10]
            end else if (wr_ctrl && REQ.wdata[SBSC_CTRL_ACK_TRIG]) begin
                manual_ack_trigger <= 1'b1;
            end else if (sck_fall && state == SBSC_ST_READY) begin
                manual_ack_trigger <= 1'b0; // [RULE9]
            end
        end
    end

    // Auto ack fires once per frame, whenever it is enabled
    assign ack_request = manual_ack_trigger || // [RULE11]
        (auto_ack_enable && frame_done && !ack_given); // [RULE12] [RULE13]

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            ack_given <= 1'b0;
        end else if (CE) begin
            if (!channel_op_enable || SHIFT.start) begin
                ack_given <= 1'b0;
            end else if (sck_fall && state == SBSC_ST_READY && ack_request) begin
                ack_given <= 1'b1;
            end
        end
    end

    // Ack and busy sequencing on serial clock falls
    always_comb begin
        next_state = state;
        case (state)
            SBSC_ST_READY: begin
                if (ack_request) begin
                    next_state = SBSC_ST_ACK; // [RULE9] [RULE12]
                end
            end
            SBSC_ST_ACK: begin
                if (busy_enable) begin
                    next_state = SBSC_ST_BUSY; // [RULE16]
                end else begin
                    next_state = SBSC_ST_READY;
                end
            end
            SBSC_ST_BUSY: begin
                if (!busy_enable) begin
                    next_state = SBSC_ST_READY; // [RULE17]
                end
            end
            default: begin
                next_state = SBSC_ST_READY;
            end
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            state <= SBSC_ST_READY;
        end else if (CE) begin
            if (!channel_op_enable) begin
                state <= SBSC_ST_READY;
            end else if (SHIFT.start) begin
                // Busy enable itself is left alone
                state <= SBSC_ST_READY; // [RULE18]
            end else if (sck_fall) begin
                state <= next_state;
            end
        end
    end

    // Remembers a start so the ack flag clears on the next fall out of busy
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            start_pending <= 1'b0;
        end else if (CE) begin
            if (!channel_op_enable) begin
                start_pending <= 1'b0;
            end else if (SHIFT.start) begin
                start_pending <= 1'b1;
            end else if (sck_fall && state != SBSC_ST_BUSY) begin
                start_pending <= 1'b0;
            end
        end
    end

    // Ack detection; the set outranks the clear in the same cycle
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            ack_detected <= 1'b0; // [RULE15]
        end else if (CE) begin
            if (!channel_op_enable) begin
                ack_detected <= 1'b0; // [RULE15]
            end else if (sck_rise && frame_done && !sda_s2) begin
                ack_detected <= 1'b1; // [RULE14]
            end else if (sck_fall && start_pending && state != SBSC_ST_BUSY) begin
                ack_detected <= 1'b0; // [RULE15]
            end
        end
    end

    // Open-drain data line: only ever pulled low
    assign next_drive_low = channel_op_enable &&
        (!serial_output_latch || state != SBSC_ST_READY);

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            SDA_OE_N <= 1'b1;
        end else if (CE) begin
            SDA_OE_N <= !next_drive_low;
        end
    end

    assign SDA_O = 1'b0;
    assign CHAN_EN = channel_op_enable;
    assign WAKEUP_EN = wakeup_enable;

    // Read mux; unmapped addresses read zero
    always_comb begin
        next_rdata = 8'h00;
        case (REQ.addr)
            SBSC_ADDR_MODE: begin
                next_rdata = mode_reg;
                next_rdata[SBSC_MODE_MATCH] = 1'b0;
            end
            SBSC_ADDR_CTRL: begin
                // Trigger bits always read zero
                next_rdata[SBSC_CTRL_BUSY_EN] = busy_enable; // [RULE20]
                next_rdata[SBSC_CTRL_ACK_DET] = ack_detected; // [RULE19]
                next_rdata[SBSC_CTRL_AUTO_ACK] = auto_ack_enable;
                next_rdata[SBSC_CTRL_CMD_DET] = command_detected; // [RULE19]
                next_rdata[SBSC_CTRL_REL_DET] = release_detected; // [RULE19]
            end
            SBSC_ADDR_ITIM: begin
                next_rdata = itim_reg;
                // Synchronised clock level, forced low when off
                next_rdata[SBSC_ITIM_CLK_LEVEL] = channel_op_enable && sck_s2; // [RULE22]
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            RDATA <= 8'h00;
        end else if (CE) begin
            if (REQ.rd) begin
                RDATA <= next_rdata;
            end else begin
                RDATA <= 8'h00;
            end
        end
    end
endmodule

// file: tb/sbsc_props.sv
// Port-level assertions for the serial bus signal control block
`timescale 1ns/100ps
module sbsc_props (
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic CE,
    input wire sbsc_pkg::sbsc_req_t REQ,
    input wire logic [7:0] RDATA,
    input wire sbsc_pkg::sbsc_shift_t SHIFT,
    input wire logic SCK_IN,
    input wire logic SDA_IN,
    input wire logic SDA_O,
    input wire logic SDA_OE_N,
    input wire logic CHAN_EN,
    input wire logic WAKEUP_EN,
    input wire logic XFER_DONE
);
    import sbsc_pkg::*;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SRST);
    sequence rd_at(logic [15:0] a);
        CE && REQ.rd && REQ.addr == a;
    endsequence
    sequence wr_ctrl(logic [7:0] d);
        CE && REQ.wr && REQ.addr == SBSC_ADDR_CTRL && REQ.wdata == d;
    endsequence
    a_reset_idle:
        assert property ($fell(SRST) |-> RDATA == 8'h00 && SDA_OE_N && !CHAN_EN)
        else $error("outputs not idle after reset");
    a_cmd_pulls_low:
        assert property (wr_ctrl(8'h02) ##0 CHAN_EN |=> ##2 !SDA_OE_N)
        else $error("command trigger did not pull the line");
    a_rel_frees_line:
        assert property (wr_ctrl(8'h02) ##0 CHAN_EN ##[2:20] wr_ctrl(8'h01) |=> ##2 SDA_OE_N)
        else $error("release trigger did not free the line");
    a_off_trig_inert:
        assert property ((!CHAN_EN && SDA_OE_N && !SHIFT.load) ##0 wr_ctrl(8'h02)
            |=> SDA_OE_N [*2])
        else $error("trigger acted while disabled");
    a_trig_read_zero:
        assert property (rd_at(SBSC_ADDR_CTRL) |=> (RDATA & 8'h13) == 8'h00)
        else $error("trigger bit read back as one");
    a_off_flags_clear:
        assert property (!CHAN_EN ##1 (!CHAN_EN ##0 rd_at(SBSC_ADDR_CTRL))
            |=> (RDATA & 8'h5f) == 8'h00)
        else $error("flags or triggers set while disabled");
    a_itim_fields:
        assert property (rd_at(SBSC_ADDR_ITIM) ##0 !CHAN_EN
            |=> RDATA[3:0] == 4'h0 && !RDATA[SBSC_ITIM_CLK_LEVEL])
        else $error("timing register low bits or clock level nonzero");
    a_mode_enable:
        assert property (CE && REQ.wr && REQ.addr == SBSC_ADDR_MODE
            |=> CHAN_EN == $past(REQ.wdata[SBSC_MODE_ENABLE]))
        else $error("channel enable does not follow mode bit 7");
    a_start_restarts:
        assert property (CE && SHIFT.start && CHAN_EN |=> !XFER_DONE [*2])
        else $error("frame count not restarted by start");
endmodule
bind sbsc_top sbsc_props u_props (
    .MCLK(MCLK), .SRST(SRST), .CE(CE), .REQ(REQ), .RDATA(RDATA), .SHIFT(SHIFT),
    .SCK_IN(SCK_IN), .SDA_IN(SDA_IN), .SDA_O(SDA_O), .SDA_OE_N(SDA_OE_N),
    .CHAN_EN(CHAN_EN), .WAKEUP_EN(WAKEUP_EN), .XFER_DONE(XFER_DONE)
);

// file: tb/sbsc_peer.sv
// Behavioural bus master driving the serial clock and the shared data line
`timescale 1ns/100ps
module sbsc_peer (
    input wire logic clk,
    input wire logic oe_n,
    output logic sck,
    output logic sda
);
    logic drv;
    initial begin
        sck = 1'b1;
        drv = 1'b1;
    end
    // Pull-up: whoever pulls low wins, a released line reads high
    assign sda = drv & oe_n;
    // Half a 320 ns clock period; the clock rests high between frames
    task automatic half(input logic lvl);
        @(posedge clk);
        sck <= lvl;
        repeat (3) @(posedge clk);
    endtask
    task automatic clocks(input int n);
        repeat (n) begin
            half(1'b0);
            half(1'b1);
        end
    endtask
    // Data edge while the clock is high: falling is command, rising is release
    task automatic cond(input logic lvl);
        @(posedge clk);
        drv <= lvl;
        repeat (5) @(posedge clk);
    endtask
endmodule

// file: tb/sbsc_tb_top.sv
// Self-checking bench for the serial bus signal control block
`timescale 1ns/100ps
module sbsc_tb_top;
    import sbsc_pkg::*;
    localparam logic [15:0] ctl = SBSC_ADDR_CTRL;
    localparam logic [15:0] mde = SBSC_ADDR_MODE;
    localparam logic [15:0] itm = SBSC_ADDR_ITIM;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    sbsc_req_t req = '0;
    sbsc_shift_t shift = '0;
    logic [7:0] rdata;
    logic sck, sda, sda_oe_n, done;
    logic ce = 1'b1;
    logic sda_o, chan_en, wake_en;
    int errors = 0;
    int num_checks = 0;
    initial forever #20 mclk = ~mclk;
    sbsc_top uut (.MCLK(mclk), .SRST(srst), .CE(ce), .REQ(req), .RDATA(rdata),
        .SHIFT(shift), .SCK_IN(sck), .SDA_IN(sda), .SDA_O(sda_o), .SDA_OE_N(sda_oe_n),
        .CHAN_EN(chan_en), .WAKEUP_EN(wake_en), .XFER_DONE(done));
    sbsc_peer peer (.clk(mclk), .oe_n(sda_oe_n), .sck(sck), .sda(sda));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk);
        req <= '0;
    endtask
    // Leading idle cycles let synchronised line events reach the flags
    task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
        repeat (3) @(posedge mclk);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge mclk);
        req <= '0;
        @(negedge mclk);
        chk(rdata, exp);
    endtask
    task automatic pulse(input sbsc_shift_t p);
        @(posedge mclk);
        shift <= p;
        @(posedge mclk);
        shift <= '0;
    endtask
    task automatic oe(input logic e);
        repeat (4) @(negedge mclk);
        chk({7'h00, sda_oe_n}, {7'h00, e});
    endtask
    task automatic t_regs;
        rdc(ctl, 8'h00);
        rdc(mde, 8'h00);
        rdc(itm, 8'h00);
        wr(itm, 8'hf0);
        rdc(itm, 8'hb0);
        wr(itm, 8'h00);
        wr(16'hff63, 8'h5a);
        rdc(16'hff63, 8'h00);
        $display("test regs done");
    endtask
    // A write while the enable is low must leave no trace
    task automatic t_ce;
        @(posedge mclk);
        ce <= 1'b0;
        wr(itm, 8'hb0);
        @(posedge mclk);
        ce <= 1'b1;
        rdc(itm, 8'h00);
        $display("test clock enable done");
    endtask
    task automatic t_cond;
        wr(mde, 8'h80);
        wr(ctl, 8'h02);
        oe(1'b0);
        rdc(ctl, 8'h08);
        wr(ctl, 8'h01);
        oe(1'b1);
        rdc(ctl, 8'h04);
        wr(ctl, 8'h4c);
        rdc(ctl, 8'h04);
        // Shift logic drives the latch low, then high, while the clock rests high
        pulse(4'h2);
        oe(1'b0);
        rdc(ctl, 8'h0c);
        pulse(4'h3);
        oe(1'b1);
        rdc(ctl, 8'h04);
        peer.cond(1'b0);
        rdc(ctl, 8'h0c);
        pulse(4'h8);
        rdc(ctl, 8'h00);
        peer.cond(1'b1);
        wr(mde, 8'ha0);
        @(negedge mclk);
        chk({5'h00, sda_o, wake_en, chan_en}, 8'h03);
        pulse(4'h4);
        rdc(ctl, 8'h00);
        peer.cond(1'b0);
        wr(mde, 8'h00);
        @(negedge mclk);
        chk({5'h00, sda_o, wake_en, chan_en}, 8'h00);
        rdc(ctl, 8'h00);
        wr(ctl, 8'h02);
        oe(1'b1);
        rdc(itm, 8'h00);
        peer.cond(1'b1);
        // A trigger written while disabled must not reach the latch
        wr(mde, 8'h80);
        oe(1'b1);
        $display("test conditions done");
    endtask
    task automatic t_auto;
        wr(mde, 8'h80);
        wr(ctl, 8'ha0);
        pulse(4'h8);
        peer.clocks(8);
        @(negedge mclk);
        chk({7'h00, done}, 8'h01);
        peer.half(1'b0);
        peer.half(1'b1);
        oe(1'b0);
        rdc(ctl, 8'he0);
        peer.half(1'b0);
        oe(1'b0);
        pulse(4'h8);
        oe(1'b1);
        peer.half(1'b1);
        peer.half(1'b0);
        rdc(ctl, 8'ha0);
        peer.half(1'b1);
        $display("test auto ack done");
    endtask
    task automatic t_manual;
        wr(ctl, 8'h80);
        pulse(4'h8);
        peer.clocks(9);
        oe(1'b1);
        wr(ctl, 8'h90);
        peer.half(1'b0);
        oe(1'b0);
        peer.half(1'b1);
        rdc(ctl, 8'hc0);
        peer.half(1'b0);
        oe(1'b0);
        wr(ctl, 8'h00);
        peer.half(1'b1);
        peer.half(1'b0);
        oe(1'b1);
        peer.half(1'b1);
        $display("test manual ack done");
    endtask
    // Auto ack switched on after the frame, then a reset in mid-run
    task automatic t_late;
        pulse(4'h8);
        peer.clocks(9);
        rdc(itm, 8'h40);
        oe(1'b1);
        wr(ctl, 8'h20);
        peer.half(1'b0);
        oe(1'b0);
        peer.half(1'b1);
        peer.half(1'b0);
        oe(1'b1);
        rdc(ctl, 8'h60);
        peer.half(1'b1);
        @(posedge mclk);
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        rdc(ctl, 8'h00);
        rdc(mde, 8'h00);
        $display("test late ack and reset done");
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
        t_regs();
        t_ce();
        t_cond();
        t_auto();
        t_manual();
        t_late();
        print_verdict();
    end
endmodule
